// File: hdl/oamcs_pkg.sv
// Constants of the OAM center-side control register pair.
// Assumes an 8-bit register space reached through the serial management port.
package oamcs_pkg;
  localparam logic [7:0] OAMCS_ADDR_OFS   = 8'h40;
  localparam logic [7:0] OAMCS_STAT_OFS   = 8'h41;
  localparam logic [7:0] OAMCS_ADDR_RST   = 8'h01;
  localparam logic [7:0] OAMCS_STAT_RST   = 8'h00;
  localparam int         OAMCS_CNT_MSB    = 7;
  localparam int         OAMCS_CNT_LSB    = 5;
  localparam int         OAMCS_BASE_MSB   = 4;
  localparam int         OAMCS_BASE_LSB   = 0;
  localparam logic [2:0] OAMCS_CNT_MAX    = 3'h4;
  localparam logic [4:0] OAMCS_BASE_MIN   = 5'h01;
  localparam logic [4:0] OAMCS_BASE_MAX   = 5'h1D;
  localparam int         OAMCS_BUSY_BIT   = 7;
  localparam int         OAMCS_VEND_BIT   = 6;
  localparam int         OAMCS_OPTB_BIT   = 2;
  localparam int         OAMCS_OPTA_BIT   = 1;
  localparam int         OAMCS_REQ_BIT    = 0;
  localparam logic [7:0] OAMCS_STAT_WMASK = 8'h46;
  localparam logic [1:0] OAMCS_ROLE_CENTER = 2'h1;
  typedef enum logic [1:0] {
    OAMCS_FR_CENTER   = 2'h0,
    OAMCS_FR_TERMINAL = 2'h1,
    OAMCS_FR_LOOPSTOP = 2'h2,
    OAMCS_FR_OTHER    = 2'h3
  } oamcs_frame_e;
  typedef enum logic [1:0] {
    OAMCS_ST_IDLE = 2'h0,
    OAMCS_ST_SEND = 2'h1,
    OAMCS_ST_GAP  = 2'h3
  } oamcs_state_e;
endpackage : oamcs_pkg

// File: hdl/oamcs_rep_if.sv
// Link between the register bank and its frame repeat engine.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface oamcs_rep_if;
  import oamcs_pkg::*;
  logic         start;
  oamcs_frame_e kind;
  logic [2:0]   count_code;
  logic         tx_ready;
  logic         busy;
  logic         send;
  oamcs_frame_e send_kind;
  modport ctl (output start, kind, count_code, tx_ready, input busy, send, send_kind);
  modport rep (input start, kind, count_code, tx_ready, output busy, send, send_kind);
endinterface : oamcs_rep_if
`default_nettype wire

// File: hdl/oamcs_repeat.sv
// Frame repeat engine: emits one send strobe per frame copy.
// Assumes the transmitter raises tx_ready when it can take a frame.
`timescale 1ns/1ps
`default_nettype none
module oamcs_repeat (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  oamcs_rep_if.rep    rif
);
  import oamcs_pkg::*;

  oamcs_state_e state;
  oamcs_state_e next_state;
  logic [2:0]   left;
  logic [2:0]   next_left;
  logic         repeatable;
  logic         fire;

  assign repeatable = (rif.kind != OAMCS_FR_OTHER);
  assign fire       = (state == OAMCS_ST_SEND) && rif.tx_ready;
  assign rif.busy   = (state != OAMCS_ST_IDLE);

  always_comb begin
    next_state = state;
    next_left  = left;
    case (state)
      OAMCS_ST_IDLE: begin
        if (rif.start) begin
          next_state = OAMCS_ST_SEND;
          next_left  = repeatable ? rif.count_code : 3'h0;
        end
      end
      OAMCS_ST_SEND: begin
        if (fire) begin
          next_state = (left == 3'h0) ? OAMCS_ST_IDLE : OAMCS_ST_GAP;
          next_left  = (left == 3'h0) ? 3'h0 : left - 3'h1;
        end
      end
      OAMCS_ST_GAP: next_state = OAMCS_ST_SEND;
      default: next_state = OAMCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= OAMCS_ST_IDLE;
      left          <= 3'h0;
      rif.send      <= 1'b0;
      rif.send_kind <= OAMCS_FR_OTHER;
    end else begin
      state    <= next_state;
      left     <= next_left;
      rif.send <= fire;
      if (rif.start && state == OAMCS_ST_IDLE) begin
        rif.send_kind <= rif.kind;
      end
    end
  end
endmodule : oamcs_repeat
`default_nettype wire

// File: hdl/oamcs_regs.sv
// OAM center-side control registers: indication count, PHY base address,
// center-side status and options, plus the frame repeat control.
// Assumes a serial management front end that turns accesses into
// one-cycle read and write strobes, and status change pulses from the OAM core.
//
// What this block does
// - Send count-field-plus-one copies per status change
// - Repeat only center, terminal, loop-stop indications
// - Base field holds port 1 address, reset 1
// - Port 2 answers at port 1 address plus one
// - Center mode idle until a valid base address is written
// - Busy reads loopback or reply pending
// - Vendor bit low enables vendor code compare
// - Option b clears terminal flags six to ten
// - Option a suppresses center condition frame
// - Request flag set on watched register change
// - Status register acts only in center role
`timescale 1ns/1ps
`default_nettype none
module oamcs_regs (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_I,
  input  wire logic [7:0]             REG_ADDR_I,
  input  wire logic                   REG_WR_I,
  input  wire logic                   REG_RD_I,
  input  wire logic [7:0]             REG_WDATA_I,
  output logic      [7:0]             REG_RDATA_O,
  output logic                        REG_RVALID_O,
  input  wire logic                   CONVERTER_ROLE_STRAP_HIGH_I,
  input  wire logic                   CONVERTER_ROLE_STRAP_LOW_I,
  input  wire logic                   LOOPBACK_ACTIVE_I,
  input  wire logic                   REPLY_PENDING_I,
  input  wire logic                   WATCHED_CHANGE_I,
  input  wire logic [4:0]             MGMT_PHY_ADDR_I,
  output logic                        MGMT_HIT_PORT1_O,
  output logic                        MGMT_HIT_PORT2_O,
  input  wire logic                   FRAME_REQ_I,
  input  wire oamcs_pkg::oamcs_frame_e FRAME_KIND_I,
  input  wire logic                   TX_READY_I,
  output logic                        TX_SEND_O,
  output oamcs_pkg::oamcs_frame_e     TX_KIND_O,
  output logic                        FRAME_BUSY_O,
  output logic                        PORT1_ENABLE_O,
  output logic                        CENTER_RUN_O,
  output logic      [4:0]             PHY1_ADDR_O,
  output logic      [4:0]             PHY2_ADDR_O,
  output logic                        VENDOR_COMPARE_O,
  output logic                        CLEAR_TERMINAL_FLAGS_O
);
  import oamcs_pkg::*;

  oamcs_rep_if rif ();

  logic [7:0] addr_reg;
  logic [7:0] stat_opt;
  logic       request;
  logic       busy;
  logic       strap_done;
  logic       center_role;
  logic       started;
  logic       pend;

  logic       wr_addr;
  logic       wr_stat;
  logic       rd_addr;
  logic       rd_stat;
  logic [2:0] wr_cnt;
  logic [4:0] wr_base;
  logic       cnt_ok;
  logic       base_ok;
  logic [2:0] next_cnt;
  logic [4:0] next_base;
  logic [4:0] port2_addr;
  logic       next_request;
  logic [7:0] stat_view;
  logic [7:0] rd_mux;
  logic       role_center_now;
  logic       frame_allowed;
  logic [4:0] base_now;
  logic       next_started;
  logic       next_busy;
  logic       next_port1_en;
  logic       next_center_run;
  logic       next_hit_port1;
  logic       next_hit_port2;
  logic       next_vendor_cmp;
  logic       next_clear_term;
  logic       next_frame_busy;

  assign wr_addr = REG_WR_I && (REG_ADDR_I == OAMCS_ADDR_OFS);
  assign wr_stat = REG_WR_I && (REG_ADDR_I == OAMCS_STAT_OFS) && center_role;
  assign rd_addr = REG_RD_I && (REG_ADDR_I == OAMCS_ADDR_OFS);
  assign rd_stat = REG_RD_I && (REG_ADDR_I == OAMCS_STAT_OFS);

  assign wr_cnt  = REG_WDATA_I[OAMCS_CNT_MSB:OAMCS_CNT_LSB];
  assign wr_base = REG_WDATA_I[OAMCS_BASE_MSB:OAMCS_BASE_LSB];
  // Invalid codes keep the previous field so the engine never sees them
  assign cnt_ok  = (wr_cnt <= OAMCS_CNT_MAX);
  assign base_ok = (wr_base >= OAMCS_BASE_MIN) && (wr_base <= OAMCS_BASE_MAX);
  assign next_cnt  = (wr_addr && cnt_ok) ? wr_cnt : addr_reg[OAMCS_CNT_MSB:OAMCS_CNT_LSB];
  assign next_base = (wr_addr && base_ok) ? wr_base : addr_reg[OAMCS_BASE_MSB:OAMCS_BASE_LSB];
  assign port2_addr = addr_reg[OAMCS_BASE_MSB:OAMCS_BASE_LSB] + 5'h01;

  assign role_center_now = ({CONVERTER_ROLE_STRAP_HIGH_I, CONVERTER_ROLE_STRAP_LOW_I}
                            == OAMCS_ROLE_CENTER);

  // Set wins over the read clear; the flag was already latched into read data
  assign next_request = (WATCHED_CHANGE_I && center_role)
                        || (request && !rd_stat);

  // Reserved bits 5-3 always read zero; the controller must leave them alone
  assign stat_view = center_role ?
                     {busy, stat_opt[OAMCS_VEND_BIT], 3'h0, stat_opt[OAMCS_OPTB_BIT],
                      stat_opt[OAMCS_OPTA_BIT], request} : 8'h00;
  assign rd_mux = rd_addr ? addr_reg : (rd_stat ? stat_view : 8'h00);

  // Center role waits for an address write with a valid base; other roles run at once
  assign frame_allowed = (!center_role || started) && strap_done
                         && !(FRAME_KIND_I == OAMCS_FR_CENTER
                              && stat_opt[OAMCS_OPTA_BIT] && center_role);

  assign base_now        = addr_reg[OAMCS_BASE_MSB:OAMCS_BASE_LSB];
  assign next_started    = started || (wr_addr && base_ok && center_role);
  assign next_busy       = LOOPBACK_ACTIVE_I || REPLY_PENDING_I;
  assign next_port1_en   = strap_done && (!center_role || started);
  assign next_center_run = center_role && started;
  assign next_hit_port1  = (MGMT_PHY_ADDR_I == base_now);
  assign next_hit_port2  = (MGMT_PHY_ADDR_I == port2_addr);
  assign next_vendor_cmp = center_role && !stat_opt[OAMCS_VEND_BIT];
  assign next_clear_term = center_role && stat_opt[OAMCS_OPTB_BIT];
  // Drops for at least one cycle between bursts, so each burst is seen alone
  assign next_frame_busy = rif.busy || pend;

  // Requests arriving while the engine repeats are dropped, not queued
  assign rif.start      = FRAME_REQ_I && frame_allowed && !rif.busy;
  assign rif.kind       = FRAME_KIND_I;
  assign rif.count_code = addr_reg[OAMCS_CNT_MSB:OAMCS_CNT_LSB];
  assign rif.tx_ready   = TX_READY_I;
  assign TX_SEND_O      = rif.send;
  assign TX_KIND_O      = rif.send_kind;

  oamcs_repeat u_repeat (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .rif   (rif)
  );

  // Role strap is caught on the first clock after reset release
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      strap_done  <= 1'b0;
      center_role <= 1'b0;
    end else if (!strap_done) begin
      strap_done  <= 1'b1;
      center_role <= role_center_now;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      addr_reg <= OAMCS_ADDR_RST;
    end else begin
      addr_reg <= {next_cnt, next_base};
    end
  end

  // Once started the center role stays up until reset, so port 1 never drops
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      started <= 1'b0;
    end else begin
      started <= next_started;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      stat_opt <= OAMCS_STAT_RST;
    end else if (wr_stat) begin
      stat_opt <= REG_WDATA_I & OAMCS_STAT_WMASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      request <= 1'b0;
    end else begin
      request <= next_request;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
    end
  end

  // Read data holds between reads so a slow front end may pick it up late
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rd_mux;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PORT1_ENABLE_O <= 1'b0;
    end else begin
      PORT1_ENABLE_O <= next_port1_en;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CENTER_RUN_O <= 1'b0;
    end else begin
      CENTER_RUN_O <= next_center_run;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PHY1_ADDR_O <= OAMCS_ADDR_RST[OAMCS_BASE_MSB:OAMCS_BASE_LSB];
    end else begin
      PHY1_ADDR_O <= base_now;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PHY2_ADDR_O <= 5'h00;
    end else begin
      PHY2_ADDR_O <= port2_addr;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      MGMT_HIT_PORT1_O <= 1'b0;
    end else begin
      MGMT_HIT_PORT1_O <= next_hit_port1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      MGMT_HIT_PORT2_O <= 1'b0;
    end else begin
      MGMT_HIT_PORT2_O <= next_hit_port2;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      VENDOR_COMPARE_O <= 1'b0;
    end else begin
      VENDOR_COMPARE_O <= next_vendor_cmp;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CLEAR_TERMINAL_FLAGS_O <= 1'b0;
    end else begin
      CLEAR_TERMINAL_FLAGS_O <= next_clear_term;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pend <= 1'b0;
    end else begin
      pend <= rif.start;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      FRAME_BUSY_O <= 1'b0;
    end else begin
      FRAME_BUSY_O <= next_frame_busy;
    end
  end
endmodule : oamcs_regs
`default_nettype wire

// File: bench/oamcs_tx_sink.sv
// Transmitter model on the far side of the frame send strobe.
// Assumes one send strobe per frame copy; stalls one cycle in four.
`timescale 1ns/1ps
`default_nettype none
module oamcs_tx_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       send_i,
  output logic            ready_o,
  output logic [3:0]      sent_o
);
  logic [1:0] phase;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase  <= 2'h0;
      sent_o <= 4'h0;
    end else begin
      phase <= phase + 2'h1;
      if (send_i) sent_o <= sent_o + 4'h1;
    end
  end
  // Regular stalls so copies must wait for ready, as a real link would
  assign ready_o = (phase != 2'h3);
endmodule : oamcs_tx_sink
`default_nettype wire

// File: bench/oamcs_regs_assertions.sv
// Checker for the register pair, bound to its top ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module oamcs_regs_chk (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       REG_RD_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RVALID_O,
  input wire logic [4:0] PHY1_ADDR_O,
  input wire logic [4:0] PHY2_ADDR_O,
  input wire logic       PORT1_ENABLE_O,
  input wire logic       CENTER_RUN_O,
  input wire logic       TX_SEND_O,
  input wire logic       FRAME_BUSY_O
);
  logic [3:0] copies;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Copies of one request; cleared while idle
  always_ff @(posedge CLK_I) begin
    if (RST_I || !FRAME_BUSY_O) copies <= 4'h0;
    else if (TX_SEND_O) copies <= copies + 4'h1;
  end
  // Two quiet cycles skip reset release, while port 2 still holds its reset value of zero
  sequence s_base_quiet;
    !RST_I ##1 $stable(PHY1_ADDR_O) [*2];
  endsequence
  a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read strobe not answered next cycle");
  a_valid_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("read valid without read strobe");
  a_port2_offset: assert property (s_base_quiet |-> PHY2_ADDR_O == PHY1_ADDR_O + 5'h01)
    else $error("port 2 address not port 1 plus one");
  a_base_range: assert property (PHY1_ADDR_O >= 5'h01 && PHY1_ADDR_O <= 5'h1D)
    else $error("port 1 address outside valid codes");
  a_port1_sticky: assert property (PORT1_ENABLE_O |=> PORT1_ENABLE_O)
    else $error("port 1 enable dropped");
  a_run_cause: assert property ($rose(CENTER_RUN_O) |-> $past(REG_WR_I, 2) || $past(REG_WR_I, 3))
    else $error("center run started without a write");
  a_copy_gap: assert property (TX_SEND_O |=> !TX_SEND_O)
    else $error("frame copies back to back");
  a_copy_limit: assert property (copies <= 4'h5)
    else $error("more than five copies");
endmodule : oamcs_regs_chk
bind oamcs_regs oamcs_regs_chk u_chk (
  .CLK_I          (CLK_I),
  .RST_I          (RST_I),
  .REG_RD_I       (REG_RD_I),
  .REG_WR_I       (REG_WR_I),
  .REG_RVALID_O   (REG_RVALID_O),
  .PHY1_ADDR_O    (PHY1_ADDR_O),
  .PHY2_ADDR_O    (PHY2_ADDR_O),
  .PORT1_ENABLE_O (PORT1_ENABLE_O),
  .CENTER_RUN_O   (CENTER_RUN_O),
  .TX_SEND_O      (TX_SEND_O),
  .FRAME_BUSY_O   (FRAME_BUSY_O)
);
`default_nettype wire

// File: bench/oamcs_regs_tb_top.sv
// Self-checking bench for the register pair and frame repeat.
// Assumes the transmitter model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module oamcs_regs_tb_top;
  import oamcs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0, lb = 1'b0, rp = 1'b0;
  logic chg = 1'b0, sh = 1'b0, sl = 1'b1, rdy, send, busy, rv, en, run, hit1, hit2, vc, ctf;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  logic [4:0] maddr = 5'h00, p1, p2;
  logic [3:0] nsent;
  oamcs_frame_e kind = OAMCS_FR_CENTER, tkind;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #2 clk = ~clk;
  oamcs_regs dut (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .REG_RVALID_O(rv),
    .CONVERTER_ROLE_STRAP_HIGH_I(sh), .CONVERTER_ROLE_STRAP_LOW_I(sl),
    .LOOPBACK_ACTIVE_I(lb), .REPLY_PENDING_I(rp), .WATCHED_CHANGE_I(chg),
    .MGMT_PHY_ADDR_I(maddr), .MGMT_HIT_PORT1_O(hit1), .MGMT_HIT_PORT2_O(hit2),
    .FRAME_REQ_I(req), .FRAME_KIND_I(kind), .TX_READY_I(rdy), .TX_SEND_O(send),
    .TX_KIND_O(tkind), .FRAME_BUSY_O(busy), .PORT1_ENABLE_O(en), .CENTER_RUN_O(run),
    .PHY1_ADDR_O(p1), .PHY2_ADDR_O(p2), .VENDOR_COMPARE_O(vc),
    .CLEAR_TERMINAL_FLAGS_O(ctf));
  oamcs_tx_sink u_sink (.clk_i(clk), .rst_i(rst), .send_i(send), .ready_o(rdy),
    .sent_o(nsent));
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Single byte accesses only, one-cycle strobes
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wd <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk);
    chk(8'(rv), 8'h01);
    chk(rdat, exp);
  endtask : rreg
  task automatic frame(input oamcs_frame_e k, input logic [3:0] exp);
    logic [3:0] n0;
    logic [3:0] d;
    int i;
    n0 = nsent;
    i = 0;
    @(posedge clk) begin req <= 1'b1; kind <= k; end
    @(posedge clk) req <= 1'b0;
    // Busy output rises one edge after the request is taken
    repeat (2) @(negedge clk);
    while (busy === 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (i == 100) n_errors++;
    repeat (3) @(negedge clk);
    d = nsent - n0;
    chk(8'(d), 8'(exp));
    if (exp != 4'h0) chk(8'(tkind), 8'(k));
  endtask : frame
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    rreg(8'h40, 8'h01);
    rreg(8'h41, 8'h00);
    chk(8'(en), 8'h00);
    frame(OAMCS_FR_TERMINAL, 4'h0);
    wreg(8'h40, 8'h45);
    repeat (3) @(negedge clk);
    chk(8'({en, run}), 8'h03);
    chk(8'(p2), 8'h06);
    chk(8'(p1), 8'h05);
    @(posedge clk) maddr <= 5'h06;
    repeat (2) @(negedge clk);
    chk(8'({hit1, hit2}), 8'h01);
    wreg(8'h40, 8'hBE);
    rreg(8'h40, 8'h45);
    wreg(8'h40, 8'h60);
    rreg(8'h40, 8'h65);
    wreg(8'h40, 8'h9D);
    rreg(8'h40, 8'h9D);
    for (int k = 0; k < 4; k++) frame(oamcs_frame_e'(k), (k < 3) ? 4'h5 : 4'h1);
    wreg(8'h41, 8'h47);
    rreg(8'h41, 8'h46);
    chk(8'({vc, ctf}), 8'h01);
    frame(OAMCS_FR_CENTER, 4'h0);
    frame(OAMCS_FR_LOOPSTOP, 4'h5);
    wreg(8'h41, 8'h00);
    repeat (2) @(negedge clk);
    chk(8'({vc, ctf}), 8'h02);
    frame(OAMCS_FR_CENTER, 4'h5);
    @(posedge clk) lb <= 1'b1;
    rreg(8'h41, 8'h80);
    @(posedge clk) begin lb <= 1'b0; rp <= 1'b1; end
    rreg(8'h41, 8'h80);
    @(posedge clk) rp <= 1'b0;
    rreg(8'h41, 8'h00);
    @(posedge clk) chg <= 1'b1;
    @(posedge clk) chg <= 1'b0;
    rreg(8'h41, 8'h01);
    rreg(8'h41, 8'h00);
    @(posedge clk) begin chg <= 1'b1; rd <= 1'b1; end
    @(posedge clk) begin chg <= 1'b0; rd <= 1'b0; end
    @(negedge clk);
    chk(rdat, 8'h00);
    rreg(8'h41, 8'h01);
    rreg(8'h41, 8'h00);
    wreg(8'h42, 8'hFF);
    rreg(8'h42, 8'h00);
    @(posedge clk) begin rst <= 1'b1; sh <= 1'b1; sl <= 1'b0; end
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    chk(8'({en, run}), 8'h02);
    @(posedge clk) chg <= 1'b1;
    @(posedge clk) chg <= 1'b0;
    wreg(8'h41, 8'h46);
    rreg(8'h41, 8'h00);
    test_done;
  end
endmodule : oamcs_regs_tb_top
`default_nettype wire
